// >>> testbench.sv
// Self-checking bench for the channel two timer.
// Assumes tipg_timer and its package are compiled first.
`timescale 1ns/1ps
module testbench
  import tipg_pkg::*;
;
  logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, irq_ack = 0, rd_d = 0;
  logic [11:0] reg_addr = 0;
  logic [7:0]  reg_wdata = 0, reg_wmask = 0, n, h;
  wire [7:0]   reg_rdata;
  wire         ch2_irq_flag, ch2_out_pin;
  logic [7:0]  exp_q[$];
  int          fails = 0, n_checks = 0, cyc = 0, c, e;
  int          dv[8] = '{0, 0, 2, 1, 1024, 256, 64, 16};
  tipg_timer tipg_timer_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_wmask(reg_wmask), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_ack(irq_ack), .ch2_irq_flag(ch2_irq_flag), .ch2_out_pin(ch2_out_pin));
  always #5 clk = ~clk;
  // Verdict and end of run
  task end_sim;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_wmask <= m; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read request; expectation goes on the queue
  task rd(input logic [11:0] a, input logic [7:0] x);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1'b1; exp_q.push_back(x);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  // Wait for an irq, acknowledge, count cycles and pin changes to the next
  task span(output int cn, output int ed);
    logic p;
    cn = 0; ed = 0;
    // Let the start write settle so a stale flag is not taken as the first irq
    @(posedge clk);
    while (ch2_irq_flag !== 1'b1 && cn < 9000) begin
      @(posedge clk); cn++;
    end
    irq_ack <= 1'b1; p = ch2_out_pin; cn = 0;
    do begin
      @(posedge clk); irq_ack <= 1'b0; cn++;
      if (ch2_out_pin !== p) ed++;
      p = ch2_out_pin;
    end while ((cn < 3 || ch2_irq_flag !== 1'b1) && cn < 9000);
  endtask
  // Read result monitor
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) if (rd_d) cmp({24'h0, reg_rdata}, {24'h0, exp_q.pop_front()});
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++; end_sim;
    end
  end
  initial begin
    void'($urandom(19));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(MODE_ADDR, MODE_RESET);
    rd(CTRL_ADDR, CTRL_RESET);
    rd(COUNT_ADDR, 8'h00);
    wr(12'hf9c, 8'h55, 8'hff);
    rd(12'hf9c, 8'h00);
    $display("reset test done");
    // Interval for every count pulse code
    for (int s = 2; s < 8; s++) begin
      n = 8'($urandom_range(4, 2));
      wr(LOW_PER_ADDR, n, 8'hff);
      wr(MODE_ADDR, {1'b0, s[2:0], 4'hc}, 8'hff);
      span(c, e);
      cmp(c, (n + 1) * dv[s]);
    end
    $display("interval test done");
    wr(LOW_PER_ADDR, 8'hff, 8'hff);
    wr(MODE_ADDR, 8'h38, 8'hff);
    repeat (20) @(posedge clk);
    cmp({31'h0, ch2_irq_flag}, 0);
    rd(COUNT_ADDR, 8'h00);
    $display("halt test done");
    h = 8'($urandom_range(4, 2));
    n = 8'($urandom_range(4, 2));
    wr(CTRL_ADDR, 8'h08, 8'hff);
    wr(HIGH_PER_ADDR, h, 8'hff);
    wr(LOW_PER_ADDR, n, 8'hff);
    wr(MODE_ADDR, 8'h3d, 8'hff);
    rd(MODE_ADDR, 8'h35);
    span(c, e);
    cmp(e, 2);
    wr(MODE_ADDR, 8'h08, 8'h08);
    rd(MODE_ADDR, 8'h35);
    cmp({31'h0, ch2_irq_flag}, 0);
    wr(CTRL_ADDR, 8'h00, 8'h08);
    repeat (30) @(posedge clk);
    cmp({31'h0, ch2_out_pin}, 0);
    $display("pwm test done");
    repeat (3) @(posedge clk);
    end_sim;
  end
endmodule

// >>> tipg_pkg.sv
// Package for the channel two timer / PWM generator.
// Assumes a single 100 MHz system clock and an internal register port.
package tipg_pkg;
  // Register addresses on the internal register port
  localparam logic [11:0] MODE_ADDR      = 12'hf90;
  localparam logic [11:0] CTRL_ADDR      = 12'hf92;
  localparam logic [11:0] HIGH_PER_ADDR  = 12'hf94;
  localparam logic [11:0] LOW_PER_ADDR   = 12'hf96;
  localparam logic [11:0] COUNT_ADDR     = 12'hf98;
  localparam logic [11:0] STATUS_ADDR    = 12'hf9a;
  // Mode and control register field positions
  localparam int MODE_START_BIT = 3;
  localparam int MODE_RUN_BIT   = 2;
  localparam int MODE_SEL_HI    = 1;
  localparam int MODE_SEL_LO    = 0;
  localparam int MODE_PSEL_LSB  = 4;
  localparam int CTRL_OE_BIT    = 3;
  // Reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PER_RESET  = 8'hff;
  // Operation mode codes (sel_hi, sel_lo)
  localparam logic [1:0] OPMODE_TIMER = 2'h0;
  localparam logic [1:0] OPMODE_PWM   = 2'h1;
  // Count pulse select codes
  localparam logic [2:0] PSEL_DIV2    = 3'h2;
  localparam logic [2:0] PSEL_DIV1    = 3'h3;
  localparam logic [2:0] PSEL_DIV1024 = 3'h4;
  localparam logic [2:0] PSEL_DIV256  = 3'h5;
  localparam logic [2:0] PSEL_DIV64   = 3'h6;
  localparam logic [2:0] PSEL_DIV16   = 3'h7;
  // Prescaler width, enough for the longest division
  localparam int PRESC_W = 10;
  // Compare target states
  typedef enum logic {TGT_HIGH, TGT_LOW} tipg_tgt_t;
endpackage

// >>> tipg_prescaler.sv
// Free-running prescaler producing one-cycle tap pulses of the system clock.
// Assumes the caller picks a tap; all taps run from reset.
`timescale 1ns/1ps
module tipg_prescaler
  import tipg_pkg::*;
#(
  parameter int W = PRESC_W
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Tap pulses, bit k is high one cycle in 2**(k+1)
  output logic [W-1:0] tap_pulse
);
  logic [W-1:0] cnt_q;

  // Binary divider chain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= '0;
    else        cnt_q <= cnt_q + 1'b1;
  end

  // One pulse per wrap of each low slice of the counter
  genvar k;
  generate
    for (k = 0; k < W; k++) begin : g_tap
      assign tap_pulse[k] = &cnt_q[k:0];
    end
  endgenerate
endmodule

// >>> tipg_properties.sv
// Port checker for the channel two timer.
// Assumes it is bound to tipg_timer.
`timescale 1ns/1ps
module tipg_properties
  import tipg_pkg::*;
(
  // Watched ports
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_wmask,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        irq_ack,
  input wire logic        ch2_irq_flag,
  input wire logic        ch2_out_pin
);
  logic oe_q;
  // Decoded start write and unmapped address
  wire st = reg_wr && reg_addr == MODE_ADDR && reg_wmask[3] && reg_wdata[3];
  wire um = reg_addr[11:4] != 8'hf9 || reg_addr[0] || reg_addr[3:1] > 3'h5;
  // Mirror of the output enable flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) oe_q <= 1'b0;
    else if (reg_wr && reg_addr == CTRL_ADDR && reg_wmask[3]) oe_q <= reg_wdata[3];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_start_clr_irq: assert property (st |=> !ch2_irq_flag)
    else $error("irq flag not cleared by start");
  a_irq_holds: assert property (ch2_irq_flag && !irq_ack && !st |=> ch2_irq_flag)
    else $error("irq flag dropped");
  a_oe_low_pin: assert property (!oe_q |=> !ch2_out_pin)
    else $error("pin high while disabled");
  a_match_toggles_pin: assert property ($rose(ch2_irq_flag) && oe_q && $past(oe_q)
    |-> $changed(ch2_out_pin))
    else $error("pin did not toggle on match");
  a_unmapped_read: assert property (reg_rd && um |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed");
  a_mode_read_bits: assert property (reg_rd && reg_addr == MODE_ADDR
    |=> reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0)
    else $error("mode bit 7 or start read high");
  a_status_irq_bit: assert property (reg_rd && reg_addr == STATUS_ADDR
    |=> reg_rdata[0] == $past(ch2_irq_flag))
    else $error("status irq bit wrong");
  c_start: cover property (st);
  c_irq: cover property ($rose(ch2_irq_flag));
  c_pin: cover property ($rose(ch2_out_pin));
endmodule
bind tipg_timer tipg_properties tipg_properties_i (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_wmask(reg_wmask),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_ack(irq_ack),
  .ch2_irq_flag(ch2_irq_flag), .ch2_out_pin(ch2_out_pin));

// >>> tipg_pulse_sel.sv
// Count pulse selector for channel two.
// Assumes tap pulses from the prescaler; prohibited codes give no pulse.
`timescale 1ns/1ps
module tipg_pulse_sel
  import tipg_pkg::*;
(
  // Selection
  input  wire logic [2:0]         psel,
  input  wire logic [PRESC_W-1:0] tap_pulse,
  // Selected count pulse
  output logic                    count_pulse
);
  // Decode the select code onto a tap
  assign count_pulse = (psel == PSEL_DIV1)    ? 1'b1 :
                       (psel == PSEL_DIV2)    ? tap_pulse[0] :
                       (psel == PSEL_DIV1024) ? tap_pulse[9] :
                       (psel == PSEL_DIV256)  ? tap_pulse[7] :
                       (psel == PSEL_DIV64)   ? tap_pulse[5] :
                       (psel == PSEL_DIV16)   ? tap_pulse[3] : 1'b0;
endmodule

// >>> tipg_timer.sv
// Channel two 8-bit interval timer and PWM pulse generator.
// Assumes software writes registers over the internal byte register port.
//
// Overview of operation
// - Count register advances once per count pulse chosen by the mode register.
// - Timer mode: count equal to compare sets irq flag and toggles output.
// - Match interval equals compare value plus one count pulses, repeating.
// - Writing start bit clears count and irq flag; counting follows if run set.
// - Start bit self-clears; it alone is writable singly.
// - Run bit zero holds the count; one lets it count.
// - Bits 6..4 select the count pulse from the prescaled clock.
// - Mode bits 1,0 equal 0,1 select PWM mode.
// - Reset clears the mode register to zero.
// - Output enable low forces pin low; high passes the toggle flop.
// - Reset clears the control register; it accepts byte, nibble, bit writes.
// - PWM high-period match toggles output, switches to low period, no irq.
// - PWM low-period match sets irq, toggles output, switches to high period.
// - Irq set signal fires only on a low-period match.
// - Channels zero and one stay independent; nothing here touches them.
`timescale 1ns/1ps
module tipg_timer
  import tipg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [11:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic [7:0]  reg_wmask,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // Interrupt flag acknowledge from the interrupt controller
  input  wire logic        irq_ack,
  // Status
  output logic             ch2_irq_flag,
  output logic             ch2_out_pin
);
  // Registers
  logic [7:0]  mode_q, mode_d;
  logic [7:0]  ctrl_q, ctrl_d;
  logic [7:0]  high_period_q, high_period_d;
  logic [7:0]  low_period_q, low_period_d;
  logic [7:0]  count_q, count_d;
  logic        irq_q, irq_d;
  logic        tff_q, tff_d;
  logic        pin_q, pin_d;
  logic [7:0]  rdata_q, rdata_d;
  tipg_tgt_t   tgt_q, tgt_d;

  // Prescaler and pulse selection, private to channel two
  logic [PRESC_W-1:0] tap_pulse;
  logic               count_pulse;

  tipg_prescaler #(
    .W (PRESC_W)
  ) u_presc (
    .clk       (clk),
    .rst_n     (rst_n),
    .tap_pulse (tap_pulse)
  );

  tipg_pulse_sel u_psel (
    .psel        (mode_q[MODE_PSEL_LSB+2:MODE_PSEL_LSB]),
    .tap_pulse   (tap_pulse),
    .count_pulse (count_pulse)
  );

  // Address decode
  wire wr_mode  = reg_wr && (reg_addr == MODE_ADDR);
  wire wr_ctrl  = reg_wr && (reg_addr == CTRL_ADDR);
  wire wr_high  = reg_wr && (reg_addr == HIGH_PER_ADDR);
  wire wr_low   = reg_wr && (reg_addr == LOW_PER_ADDR);

  // Start bit write: any mode write with bit 3 set in both mask and data
  wire start_wr = wr_mode && reg_wmask[MODE_START_BIT] && reg_wdata[MODE_START_BIT];
  wire byte_wr  = wr_mode && (reg_wmask == 8'hff);

  // Mode decode
  wire [1:0] opmode  = mode_q[MODE_SEL_HI:MODE_SEL_LO];
  wire       pwm_on  = (opmode == OPMODE_PWM);
  wire       running = mode_q[MODE_RUN_BIT];
  wire       advance = running && count_pulse && !start_wr;

  // Compare target and match
  wire [7:0] target    = (pwm_on && tgt_q == TGT_HIGH) ? high_period_q : low_period_q;
  wire       match     = advance && (count_q == target);
  wire       irq_set   = match && !(pwm_on && tgt_q == TGT_HIGH);

  // Next mode: 8-bit writes for the fields, start bit self-clears
  always_comb begin
    mode_d = mode_q;
    if (byte_wr) begin
      mode_d = reg_wdata;
    end
    mode_d[7] = 1'b0;
    mode_d[MODE_START_BIT] = 1'b0;
  end

  // Control register accepts any mask of bits (byte, nibble, bit)
  assign ctrl_d        = wr_ctrl ? ((ctrl_q & ~reg_wmask) | (reg_wdata & reg_wmask)) : ctrl_q;
  assign high_period_d = wr_high ? reg_wdata : high_period_q;
  assign low_period_d  = wr_low  ? reg_wdata : low_period_q;

  // Count: start clears, match wraps to zero, pulse advances
  assign count_d = start_wr ? 8'h00 :
                   match    ? 8'h00 :
                   advance  ? count_q + 8'h01 : count_q;

  // Target alternates in PWM, restarts at high period on start
  always_comb begin
    tgt_d = tgt_q;
    if (start_wr || !pwm_on) begin
      tgt_d = TGT_HIGH;
    end else if (match) begin
      tgt_d = (tgt_q == TGT_HIGH) ? TGT_LOW : TGT_HIGH;
    end
  end

  // Irq flag: hardware set wins over acknowledge; start write clears
  assign irq_d = irq_set ? 1'b1 : ((start_wr || irq_ack) ? 1'b0 : irq_q);

  // Toggle flop inverts on every match
  assign tff_d = match ? ~tff_q : tff_q;

  // Pin is low when disabled, else the toggle flop
  assign pin_d = ctrl_q[CTRL_OE_BIT] & tff_d;

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        MODE_ADDR:     rdata_d = mode_q;
        CTRL_ADDR:     rdata_d = ctrl_q;
        HIGH_PER_ADDR: rdata_d = high_period_q;
        LOW_PER_ADDR:  rdata_d = low_period_q;
        COUNT_ADDR:    rdata_d = count_q;
        STATUS_ADDR:   rdata_d = {6'h00, tff_q, irq_q};
        default:       rdata_d = 8'h00;
      endcase
    end
  end

  // Control state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MODE_RESET;
      ctrl_q <= CTRL_RESET;
    end else begin
      mode_q <= mode_d;
      ctrl_q <= ctrl_d;
    end
  end

  // Period registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_period_q <= PER_RESET;
      low_period_q  <= PER_RESET;
    end else begin
      high_period_q <= high_period_d;
      low_period_q  <= low_period_d;
    end
  end

  // Counting state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 8'h00;
      tgt_q   <= TGT_HIGH;
      irq_q   <= 1'b0;
      tff_q   <= 1'b0;
    end else begin
      count_q <= count_d;
      tgt_q   <= tgt_d;
      irq_q   <= irq_d;
      tff_q   <= tff_d;
    end
  end

  // Registered outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q   <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      pin_q   <= pin_d;
      rdata_q <= rdata_d;
    end
  end

  assign ch2_out_pin  = pin_q;
  assign ch2_irq_flag = irq_q;
  assign reg_rdata    = rdata_q;
endmodule
